// ===== hdl/clock_system_pkg.sv
// Types shared by the clock system design
package clock_system_pkg;

    typedef logic [1:0] resp_t;

    // Loop sequencer, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM  = 4'b0010,
        ST_MEAS = 4'b0100,
        ST_ADJ  = 4'b1000
    } fll_state_e;

    // Clock source select codes
    typedef enum logic [2:0] {
        SRC_XT1  = 3'h0,
        SRC_VLO  = 3'h1,
        SRC_INTERNAL_REFERENCE_OSCILLATOR = 3'h2,
        SRC_DCO  = 3'h3,
        SRC_XT2  = 3'h5
    } clk_src_e;

    localparam resp_t RESP_OKAY = 2'b00;
    localparam resp_t RESP_SLVERR = 2'b10;

endpackage : clock_system_pkg

// ===== hdl/clock_system_regs.svh
// Register offsets, field positions, reset values and counts of the clock system
`ifndef CLOCK_SYSTEM_REGS_SVH
`define CLOCK_SYSTEM_REGS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define CS_WORD0_OFF 8'h00
`define CS_WORD1_OFF 8'h04
`define CS_WORD2_OFF 8'h08
`define CS_WORD3_OFF 8'h0c
`define CS_SELECT_OFF 8'h10
`define CS_DIVIDE_OFF 8'h14
`define CS_BYPASS_OFF 8'h18
`define CS_POWER_OFF 8'h20
`define CS_STATUS_OFF 8'h24

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define CS_TAP_LSB 8
`define CS_FRAC_LSB 3
`define CS_FRAC_DIS_BIT 0
`define CS_MCLK_SEL_LSB 0
`define CS_SUB_MAIN_CLOCK_SEL_LSB 4
`define CS_ACLK_SEL_LSB 8
`define CS_WDT_VLO_BIT 12
`define CS_MCLK_DIV_LSB 0
`define CS_ACLK_DIV_LSB 4
`define CS_BYPASS_BIT 0
`define CS_LEVEL_LSB 0
`define CS_SLEEP_REQ_BIT 3
`define CS_GEN_OFF_BIT 4
`define CS_LOOP_OFF_BIT 5

// ------------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------------
`define CS_TAP_RST 5'h10
`define CS_FRAC_RST 5'h00
`define CS_MULT_RST 10'h01f
`define CS_REFDIV_RST 3'h0
`define CS_FRAC_MAX 5'h1f
`define CS_TAP_MAX 5'h1f
`define CS_CAPTURE_EDGES 2'h2

`endif

// ===== hdl/fll_dco_clock_system.sv
// Frequency-lock loop, tuned oscillator modulator and clock tree control
//
// Notes on behaviour
// - Loop counts oscillator cycles between reference rising edges to steer tap and fraction.
// - Correction is two reference periods of capture, then one for adjust; partial captures dropped.
// - Loop stops in level 0 unless oscillator feeds aux/sub clocks, and levels 2-4 generator off.
// - Software write of tap and fraction loads exactly those values, no extra step.
// - Back-to-back writes to control words all take effect and reach the loop.
// - Sleep entry completes whatever the master and auxiliary divider ratio.
// - In levels 3 and 4 the serial clock request drops when idle and out of reset.
// - Watchdog tick from very low power oscillator halts during debug breakpoint.
// - Fraction spreads the oscillator between the selected tap and the next higher one.
// - Fraction wrap steps tap up and fraction to zero together, never tap up fraction down.
`timescale 1ns/1ps
`include "clock_system_regs.svh"
module fll_dco_clock_system
#(
    parameter int COUNT_W = 13
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output clock_system_pkg::resp_t s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output clock_system_pkg::resp_t s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_clk_pin,
    input wire logic irq_active,
    input wire logic debug_halt,
    input wire logic vlo_tick,
    input wire logic serial_tx_busy,
    input wire logic serial_rx_busy,
    input wire logic serial_soft_reset_bit,
    output logic [4:0] osc_tap_out,
    output logic loop_running,
    output logic mclk_en,
    output logic sub_main_clock_en,
    output logic aclk_en,
    output logic wdt_tick,
    output logic serial_clk_req,
    output logic low_current_ok,
    output logic sleep_done
);
    import clock_system_pkg::*;

    logic [4:0] tap_reg, frac_reg, mod_acc_reg;
    logic frac_dis_reg, bypass_reg, wdt_vlo_reg, sleep_req_reg, gen_off_reg, loop_off_reg;
    logic [9:0] mult_reg;
    logic [2:0] ref_div_reg, ref_pre_reg, mclk_sel_reg, sub_main_clock_sel_reg, aclk_sel_reg;
    logic [2:0] mclk_div_reg, aclk_div_reg, level_reg;
    fll_state_e state_reg;
    logic [COUNT_W-1:0] cnt_reg;
    logic [1:0] edge_reg;
    logic aw_hold_reg, w_hold_reg;
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic ref_rise, ref_tick, fll_run, sleep_active, wr_do, adj_apply, adj_up, adj_down;
    logic [31:0] wr_old, wr_merged, rd_word;
    logic [11:0] target;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                res[i*8 +: 8] = new_w[i*8 +: 8];
        return res;
    endfunction : merge

    // Register contents as read back at a given offset
    function automatic logic [31:0] read_word(input logic [7:0] addr);
        logic [31:0] w;
        w = 32'h0;
        case (addr)
            `CS_WORD0_OFF: w = {19'h0, tap_reg, frac_reg, 3'h0};
            `CS_WORD1_OFF: w = {31'h0, frac_dis_reg};
            `CS_WORD2_OFF: w = {22'h0, mult_reg};
            `CS_WORD3_OFF: w = {29'h0, ref_div_reg};
            `CS_SELECT_OFF: w = {19'h0, wdt_vlo_reg, 1'b0, aclk_sel_reg, 1'b0, sub_main_clock_sel_reg,
                                 1'b0, mclk_sel_reg};
            `CS_DIVIDE_OFF: w = {25'h0, aclk_div_reg, 1'b0, mclk_div_reg};
            `CS_BYPASS_OFF: w = {31'h0, bypass_reg};
            `CS_POWER_OFF: w = {26'h0, loop_off_reg, gen_off_reg, sleep_req_reg, level_reg};
            `CS_STATUS_OFF: w = {19'h0, osc_tap_out, sleep_done, low_current_ok, serial_clk_req,
                                 loop_running, state_reg};
            default: w = 32'h0;
        endcase
        return w;
    endfunction : read_word

    function automatic logic mapped(input logic [7:0] addr);
        return addr == `CS_WORD0_OFF || addr == `CS_WORD1_OFF || addr == `CS_WORD2_OFF ||
               addr == `CS_WORD3_OFF || addr == `CS_SELECT_OFF || addr == `CS_DIVIDE_OFF ||
               addr == `CS_BYPASS_OFF || addr == `CS_POWER_OFF || addr == `CS_STATUS_OFF;
    endfunction : mapped

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    // Address and data are taken independently; the write lands once both are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_hold_reg && !s_axi_bvalid;
            s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_hold_reg && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                waddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_do)
            begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign wr_do = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    // A process, so a register change refreshes read-back even when the address holds still
    always_comb
    begin
        wr_old = read_word(waddr_reg);
        wr_merged = merge(wr_old, wdata_reg, wstrb_reg);
        rd_word = read_word(s_axi_araddr);
    end

    // Read channel: one read at a time, data latched with rvalid
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control words
    // ------------------------------------------------------------------
    // Every accepted write updates at once, so close writes are never merged away
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            frac_dis_reg <= 1'b0;
            mult_reg <= `CS_MULT_RST;
            ref_div_reg <= `CS_REFDIV_RST;
            mclk_sel_reg <= SRC_DCO;
            sub_main_clock_sel_reg <= SRC_DCO;
            aclk_sel_reg <= SRC_XT1;
            wdt_vlo_reg <= 1'b0;
            mclk_div_reg <= 3'h0;
            aclk_div_reg <= 3'h0;
            bypass_reg <= 1'b0;
            level_reg <= 3'h0;
            sleep_req_reg <= 1'b0;
            gen_off_reg <= 1'b0;
            loop_off_reg <= 1'b0;
        end
        else if (wr_do)
        begin
            case (waddr_reg)
                `CS_WORD1_OFF: frac_dis_reg <= wr_merged[`CS_FRAC_DIS_BIT];
                `CS_WORD2_OFF: mult_reg <= wr_merged[9:0];
                `CS_WORD3_OFF: ref_div_reg <= wr_merged[2:0];
                `CS_SELECT_OFF:
                begin
                    mclk_sel_reg <= wr_merged[`CS_MCLK_SEL_LSB +: 3];
                    sub_main_clock_sel_reg <= wr_merged[`CS_SUB_MAIN_CLOCK_SEL_LSB +: 3];
                    aclk_sel_reg <= wr_merged[`CS_ACLK_SEL_LSB +: 3];
                    wdt_vlo_reg <= wr_merged[`CS_WDT_VLO_BIT];
                end
                `CS_DIVIDE_OFF:
                begin
                    mclk_div_reg <= wr_merged[`CS_MCLK_DIV_LSB +: 3];
                    aclk_div_reg <= wr_merged[`CS_ACLK_DIV_LSB +: 3];
                end
                `CS_BYPASS_OFF: bypass_reg <= wr_merged[`CS_BYPASS_BIT];
                `CS_POWER_OFF:
                begin
                    level_reg <= wr_merged[`CS_LEVEL_LSB +: 3];
                    sleep_req_reg <= wr_merged[`CS_SLEEP_REQ_BIT];
                    gen_off_reg <= wr_merged[`CS_GEN_OFF_BIT];
                    loop_off_reg <= wr_merged[`CS_LOOP_OFF_BIT];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Reference edges and loop enable
    // ------------------------------------------------------------------
    ref_edge_sync u_ref_sync
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(ref_clk_pin),
        .rise(ref_rise)
    );

    // Reference prescaler: the loop sees every (divide+1)-th synchronised edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ref_pre_reg <= 3'h0;
        else if (ref_rise)
            ref_pre_reg <= (ref_pre_reg >= ref_div_reg) ? 3'h0 : ref_pre_reg + 3'h1;
    end

    assign ref_tick = ref_rise && ref_pre_reg >= ref_div_reg;
    // Interrupt entry counts as active, which re-enables the loop
    assign sleep_active = sleep_req_reg && !irq_active;
    assign fll_run = !loop_off_reg &&
        !(sleep_active && level_reg == 3'h0 &&
          sub_main_clock_sel_reg != SRC_DCO && aclk_sel_reg != SRC_DCO) &&
        !(sleep_active && level_reg >= 3'h2 && level_reg <= 3'h4 && gen_off_reg);

    // ------------------------------------------------------------------
    // Lock sequencer
    // ------------------------------------------------------------------
    // Capture across two reference periods, then one period to adjust
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            edge_reg <= 2'h0;
        end
        else if (!fll_run)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE: state_reg <= ST_ARM;
                ST_ARM:
                    if (ref_tick)
                    begin
                        state_reg <= ST_MEAS;
                        cnt_reg <= '0;
                        edge_reg <= 2'h0;
                    end
                ST_MEAS:
                begin
                    if (cnt_reg != '1)
                        cnt_reg <= cnt_reg + 1'b1;
                    if (ref_tick)
                    begin
                        edge_reg <= edge_reg + 2'h1;
                        if (edge_reg + 2'h1 == `CS_CAPTURE_EDGES)
                            state_reg <= ST_ADJ;
                    end
                end
                ST_ADJ:
                    if (ref_tick)
                    begin
                        state_reg <= ST_MEAS;
                        cnt_reg <= '0;
                        edge_reg <= 2'h0;
                    end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign target = 12'({mult_reg, 1'b0}) + 12'h2;
    assign adj_apply = fll_run && state_reg == ST_ADJ && ref_tick;
    assign adj_up = COUNT_W'(target) > cnt_reg;
    assign adj_down = COUNT_W'(target) < cnt_reg;

    // Tap and fraction: a software write wins and loads exactly what was written
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tap_reg <= `CS_TAP_RST;
            frac_reg <= `CS_FRAC_RST;
        end
        else if (wr_do && waddr_reg == `CS_WORD0_OFF)
        begin
            tap_reg <= wr_merged[`CS_TAP_LSB +: 5];
            frac_reg <= wr_merged[`CS_FRAC_LSB +: 5];
        end
        else if (adj_apply && adj_up && {tap_reg, frac_reg} != 10'h3ff)
            {tap_reg, frac_reg} <= {tap_reg, frac_reg} + 10'h001;
        else if (adj_apply && adj_down && {tap_reg, frac_reg} != 10'h000)
            {tap_reg, frac_reg} <= {tap_reg, frac_reg} - 10'h001;
    end

    // ------------------------------------------------------------------
    // Modulator and clock tree outputs
    // ------------------------------------------------------------------
    // Accumulator spreads frac/32 of the cycles onto the next tap up
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mod_acc_reg <= 5'h0;
            osc_tap_out <= `CS_TAP_RST;
        end
        else
        begin
            mod_acc_reg <= mod_acc_reg + frac_reg;
            if (!frac_dis_reg && tap_reg != `CS_TAP_MAX &&
                {1'b0, mod_acc_reg} + {1'b0, frac_reg} > {1'b0, `CS_FRAC_MAX})
                osc_tap_out <= tap_reg + 5'h1;
            else
                osc_tap_out <= tap_reg;
        end
    end

    // Gating decided from the sleep state alone; dividers play no part in entry
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            loop_running <= 1'b0;
            mclk_en <= 1'b1;
            sub_main_clock_en <= 1'b1;
            aclk_en <= 1'b1;
            sleep_done <= 1'b0;
            serial_clk_req <= 1'b1;
            low_current_ok <= 1'b0;
            wdt_tick <= 1'b0;
        end
        else
        begin
            loop_running <= state_reg != ST_IDLE;
            mclk_en <= !sleep_active;
            sleep_done <= sleep_active;
            sub_main_clock_en <= !(sleep_active && (gen_off_reg || level_reg >= 3'h3));
            aclk_en <= !(sleep_active && level_reg >= 3'h4);
            serial_clk_req <= !(sleep_active && level_reg >= 3'h3 && !serial_tx_busy &&
                                !serial_rx_busy && !serial_soft_reset_bit);
            low_current_ok <= sleep_active && level_reg == 3'h4 && !bypass_reg;
            wdt_tick <= wdt_vlo_reg && vlo_tick && !debug_halt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_enter;
        !sleep_active ##1 sleep_active;
    endsequence
    sequence s_capture_done;
        state_reg == ST_MEAS && ref_tick && edge_reg == 2'h1 && fll_run;
    endsequence
    property p_sw_load;
        logic [4:0] t;
        logic [4:0] f;
        (wr_do && waddr_reg == `CS_WORD0_OFF, t = wr_merged[12:8], f = wr_merged[7:3])
            |=> tap_reg == t && frac_reg == f;
    endproperty
    a_sw_load: assert property (p_sw_load) else $error("tap/fraction not loaded as written");
    property p_loop_off;
        !fll_run |=> state_reg == ST_IDLE ##1 !loop_running;
    endproperty
    a_loop_off: assert property (p_loop_off) else $error("loop not stopped");
    property p_adjust_after_capture;
        s_capture_done |=> state_reg == ST_ADJ;
    endproperty
    a_adjust_after_capture: assert property (p_adjust_after_capture) else $error("no adjust");
    property p_no_partial;
        (state_reg != ST_ADJ && !wr_do) |=> $stable(tap_reg) && $stable(frac_reg);
    endproperty
    a_no_partial: assert property (p_no_partial) else $error("tap moved outside adjust");
    property p_wrap;
        (adj_apply && adj_up && !wr_do && frac_reg == 5'h1f && tap_reg != 5'h1f)
            |=> frac_reg == 5'h00 && tap_reg == $past(tap_reg) + 5'h1;
    endproperty
    a_wrap: assert property (p_wrap) else $error("inconsistent fraction wrap");
    property p_serial_release;
        (sleep_active && level_reg >= 3'h3 && !serial_tx_busy && !serial_rx_busy &&
         !serial_soft_reset_bit) |=> !serial_clk_req;
    endproperty
    a_serial_release: assert property (p_serial_release) else $error("serial clock held");
    property p_wdt_halt;
        debug_halt |=> !wdt_tick;
    endproperty
    a_wdt_halt: assert property (p_wdt_halt) else $error("watchdog ticked in halt");
    property p_sleep_entry;
        s_enter |=> sleep_done && !mclk_en;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry incomplete");
    property p_mod_off;
        frac_dis_reg |=> osc_tap_out == $past(tap_reg);
    endproperty
    a_mod_off: assert property (p_mod_off) else $error("modulation while disabled");

endmodule : fll_dco_clock_system

// ===== hdl/ref_edge_sync.sv
// Three-stage synchroniser and rising-edge pulse for the lock reference clock pin
`timescale 1ns/1ps
module ref_edge_sync
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic rise
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    // ------------------------------------------------------------------
    // Sampling chain
    // ------------------------------------------------------------------
    // Only the second stage reads the first, to keep metastability contained
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            level_reg <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            rise <= 1'b0;
            if (s2_reg == s3_reg && s3_reg != level_reg)
            begin
                level_reg <= s3_reg;
                rise <= s3_reg;
            end
        end
    end

endmodule : ref_edge_sync

// ===== tb/ref_osc_model.sv
// Reference oscillator and very low power tick model for the clock system
`timescale 1ns/1ps
module ref_osc_model
#(
    parameter int HALF_NS = 83
)
(
    input wire logic aclk,
    input wire logic start,
    input wire logic [3:0] edges,
    output logic ref_clk_pin,
    output logic vlo_tick,
    output logic busy
);
    logic [1:0] div_reg = 2'h0;
    // Reference idles low, so the loop only sees commanded edges; phase is unrelated to aclk
    initial
    begin
        ref_clk_pin = 1'b0;
        busy = 1'b0;
    end
    always @(posedge start)
    begin
        busy = 1'b1;
        repeat (edges)
        begin
            #(HALF_NS) ref_clk_pin = 1'b1;
            #(HALF_NS) ref_clk_pin = 1'b0;
        end
        busy = 1'b0;
    end
    // One tick in four cycles, so any sixteen-cycle window holds exactly four
    always_ff @(posedge aclk)
    begin
        div_reg <= div_reg + 2'h1;
        vlo_tick <= (div_reg == 2'h3);
    end
endmodule : ref_osc_model

// ===== tb/test_fll_dco_clock_system.sv
// Self-checking bench for the clock system through its register bus
`timescale 1ns/1ps
`include "clock_system_regs.svh"
module test_fll_dco_clock_system;
    import clock_system_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0, busy, ref_clk_pin, vlo_tick, wdt_tick;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, edges = 4'h0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, irq_active = 1'b0, debug_halt = 1'b0;
    logic serial_tx_busy = 1'b0, serial_rx_busy = 1'b0, serial_soft_reset_bit = 1'b0;
    resp_t s_axi_bresp, s_axi_rresp;
    logic [4:0] osc_tap_out;
    logic loop_running, mclk_en, sub_main_clock_en, aclk_en, serial_clk_req, low_current_ok, sleep_done;
    int errors = 0, samples_checked = 0, cycles = 0, n;

    fll_dco_clock_system u_dut (.*);
    ref_osc_model u_ref (.aclk(aclk), .start(start), .edges(edges),
        .ref_clk_pin(ref_clk_pin), .vlo_tick(vlo_tick), .busy(busy));

    // ------------------------------------------------------------------
    // Clock, watchdog on the run and closing report
    // ------------------------------------------------------------------
    always #4 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors = errors + 1;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // ------------------------------------------------------------------
    // Bus tasks; each channel is dropped at the edge that takes it
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input resp_t er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input resp_t er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd
    // Ask the reference for k edges, then allow synchroniser and update time
    task automatic burst(input logic [3:0] k);
        edges <= k;
        start <= 1'b1;
        @(posedge aclk);
        start <= 1'b0;
        do @(posedge aclk); while (busy);
        repeat (20) @(posedge aclk);
    endtask : burst
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask : settle

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`CS_WORD0_OFF, 32'h1000, RESP_OKAY);
        rd(`CS_WORD2_OFF, 32'h001f, RESP_OKAY);
        rd(8'h1c, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'h1, RESP_SLVERR);
        // Safe tap change: disable fraction, load, re-enable
        wr(`CS_WORD1_OFF, 32'h1, RESP_OKAY);
        wr(`CS_WORD0_OFF, 32'h0528, RESP_OKAY);
        settle();
        chk(32'(osc_tap_out), 32'h5);
        wr(`CS_WORD1_OFF, 32'h0, RESP_OKAY);
        rd(`CS_WORD0_OFF, 32'h0528, RESP_OKAY);
        // Back-to-back writes must both land
        wr(`CS_WORD2_OFF, 32'h03ff, RESP_OKAY);
        wr(`CS_WORD0_OFF, 32'h05f8, RESP_OKAY);
        rd(`CS_WORD2_OFF, 32'h03ff, RESP_OKAY);
        // Slow count against a high target steps up across the fraction wrap
        burst(4'h4);
        rd(`CS_WORD0_OFF, 32'h0600, RESP_OKAY);
        // Abandoned capture must not adjust anything
        wr(`CS_POWER_OFF, 32'h20, RESP_OKAY);
        wr(`CS_POWER_OFF, 32'h00, RESP_OKAY);
        burst(4'h3);
        rd(`CS_WORD0_OFF, 32'h0600, RESP_OKAY);
        wr(`CS_POWER_OFF, 32'h20, RESP_OKAY);
        wr(`CS_POWER_OFF, 32'h00, RESP_OKAY);
        wr(`CS_WORD2_OFF, 32'h0, RESP_OKAY);
        burst(4'h4);
        rd(`CS_WORD0_OFF, 32'h05f8, RESP_OKAY);
        chk(32'(loop_running), 32'h1);
        wr(`CS_POWER_OFF, 32'h1a, RESP_OKAY);
        settle();
        chk(32'(loop_running), 32'h0);
        irq_active <= 1'b1;
        settle();
        chk(32'(loop_running), 32'h1);
        irq_active <= 1'b0;
        wr(`CS_POWER_OFF, 32'h0b, RESP_OKAY);
        serial_tx_busy <= 1'b1;
        settle();
        chk(32'(serial_clk_req), 32'h1);
        serial_tx_busy <= 1'b0;
        settle();
        chk(32'(serial_clk_req), 32'h0);
        // Slow master on crystal, bypass left on, then removed
        wr(`CS_SELECT_OFF, 32'h1030, RESP_OKAY);
        wr(`CS_DIVIDE_OFF, 32'h0015, RESP_OKAY);
        wr(`CS_BYPASS_OFF, 32'h1, RESP_OKAY);
        wr(`CS_POWER_OFF, 32'h0c, RESP_OKAY);
        settle();
        chk(32'(sleep_done), 32'h1);
        chk(32'({mclk_en, sub_main_clock_en, aclk_en}), 32'h0);
        chk(32'(low_current_ok), 32'h0);
        wr(`CS_BYPASS_OFF, 32'h0, RESP_OKAY);
        settle();
        chk(32'(low_current_ok), 32'h1);
        // Level 0 with no tree on the oscillator stops the loop
        wr(`CS_SELECT_OFF, 32'h1000, RESP_OKAY);
        wr(`CS_POWER_OFF, 32'h08, RESP_OKAY);
        settle();
        chk(32'(loop_running), 32'h0);
        chk(32'({mclk_en, sub_main_clock_en, aclk_en}), 32'h3);
        for (int h = 1; h >= 0; h--)
        begin
            debug_halt <= h[0];
            settle();
            n = 0;
            repeat (16)
            begin
                @(posedge aclk);
                n += (wdt_tick === 1'b1);
            end
            chk(32'(n), h ? 32'h0 : 32'h4);
        end
        tally_and_finish();
    end
endmodule : test_fll_dco_clock_system
